// ===== verilog/bus_ext_core.v
// Purpose: extension and serial link logic of one bus extender unit
// Assumes: bus inputs are true-asserted levels synchronous to mclk_i
// Notes:   each bus output has an enable; the pad resolves the wire
`timescale 1ns/10ps
`default_nettype none
`include "bus_ext_defs.vh"

module bus_ext_core
#(
    parameter BIT_CYC = `BIT_CYC,
    parameter PP_WAIT = `PP_WAIT_CYC
)
(
    input  wire       mclk_i,
    input  wire       rst_n_i,
    input  wire       sw_ppr_latched_i,
    input  wire       sw4_on_i,
    input  wire       sw6_on_i,
    input  wire       bus_ifc_i,
    input  wire       bus_ren_i,
    input  wire       bus_atn_i,
    input  wire       bus_eoi_i,
    input  wire       bus_srq_i,
    input  wire       bus_dav_i,
    input  wire       bus_nrfd_i,
    input  wire       bus_ndac_i,
    input  wire [7:0] bus_dio_i,
    output reg  [7:0] bus_out_o,
    output reg  [7:0] bus_oe_o,
    output reg  [7:0] dio_out_o,
    output reg        dio_oe_o,
    input  wire       ser_rx_i,
    output wire       ser_tx_o,
    output wire       link_led_o,
    output wire       err_led_o,
    output wire       selftest_o
);

    // bus_out_o / bus_oe_o bit order
    localparam B_IFC = 0, B_REN = 1, B_ATN = 2, B_EOI = 3;
    localparam B_SRQ = 4, B_DAV = 5, B_NRFD = 6, B_NDAC = 7;
    localparam RX_IDLE = 1'b0, RX_BUSY = 1'b1;
    localparam FRAME_LAST = `PK_FRAME_W - 1;

    reg                   lsc_reg, rsc_reg, lac_reg, rac_reg, ls_reg, rs_reg;
    reg                   ppip_reg, resp_got_reg, link_reg, err_reg, ack_reg;
    reg  [7:0]            ppr_reg, resp_reg, rpoll_dio_reg;
    reg  [7:0]            rpoll_cnt_reg;
    reg                   rpoll_done_reg;
    reg  [`PK_DATA_W-1:0] rx_word_reg, sent_reg, prev_sent_reg;
    reg  [`PK_FRAME_W-1:0] tx_sh_reg;
    reg  [4:0]            tx_cnt_reg, rx_cnt_reg;
    reg  [7:0]            tx_tim_reg, rx_tim_reg;
    reg  [`PK_DATA_W:0]   rx_sh_reg;
    reg                   rx_st_reg;
    reg  [`PK_DATA_W-1:0] x_word;
    reg  [7:0]            bus_out_next, bus_oe_next, dio_out_next;
    reg                   dio_oe_next;

    wire selftest = ~sw4_on_i;
    assign selftest_o = selftest;

    // local levels are sensed only on lines this unit is not driving
    wire l_ifc = bus_ifc_i & ~bus_oe_o[B_IFC];
    wire l_ren = bus_ren_i & ~bus_oe_o[B_REN];
    wire l_atn = bus_atn_i & ~bus_oe_o[B_ATN];
    wire l_eoi = bus_eoi_i & ~bus_oe_o[B_EOI];
    wire l_srq = bus_srq_i & ~bus_oe_o[B_SRQ];
    wire l_dav = bus_dav_i & ~bus_oe_o[B_DAV];

    wire [7:0] r_dio = rx_word_reg[`PK_DIO_LSB+7:`PK_DIO_LSB];
    wire r_ifc = rx_word_reg[`PK_IFC];
    wire r_ren = rx_word_reg[`PK_REN];
    wire r_atn = rx_word_reg[`PK_ATN];
    wire r_eoi = rx_word_reg[`PK_EOI];
    wire r_srq = rx_word_reg[`PK_SRQ];
    wire r_dav = rx_word_reg[`PK_DAV];
    wire r_rfd = rx_word_reg[`PK_RFD];
    wire r_dac = rx_word_reg[`PK_DAC];
    wire r_rpp = rx_word_reg[`PK_RPP];

    wire rpoll = rac_reg & r_atn & r_eoi;
    wire lpoll_start = lac_reg & l_atn & l_eoi;

    ////////////////////////////////////////////////////////////////////
    // controller and source location states
    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lsc_reg <= 1'b0;
            rsc_reg <= 1'b0;
            lac_reg <= 1'b0;
            rac_reg <= 1'b0;
            ls_reg  <= 1'b0;
            rs_reg  <= 1'b0;
        end
        else if (link_reg)
        begin
            if ((l_ifc | l_ren) & ~rsc_reg)
                lsc_reg <= 1'b1;
            else if ((r_ifc | r_ren) & ~(l_ifc | l_ren))
                lsc_reg <= 1'b0;
            if ((r_ifc | r_ren) & ~lsc_reg)
                rsc_reg <= 1'b1;
            else if ((l_ifc | l_ren) & ~(r_ifc | r_ren))
                rsc_reg <= 1'b0;
            if (l_atn & ~rac_reg)
                lac_reg <= 1'b1;
            else if (r_atn & ~l_atn)
                lac_reg <= 1'b0;
            if (r_atn & ~lac_reg)
                rac_reg <= 1'b1;
            else if (l_atn & ~r_atn)
                rac_reg <= 1'b0;
            if (ppip_reg | rpoll | r_dav | r_atn)
                ls_reg <= 1'b0;
            else if (l_dav & ~rs_reg)
                ls_reg <= 1'b1;
            if (ppip_reg | rpoll | l_dav | l_atn)
                rs_reg <= 1'b0;
            else if (r_dav & ~ls_reg)
                rs_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // parallel poll, both ends
    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ppip_reg       <= 1'b0;
            resp_got_reg   <= 1'b0;
            resp_reg       <= 8'h00;
            ppr_reg        <= `PPR_RESET;
            rpoll_cnt_reg  <= 8'h00;
            rpoll_done_reg <= 1'b0;
            rpoll_dio_reg  <= 8'h00;
        end
        else
        begin
            if (!ppip_reg)
            begin
                ppip_reg     <= lpoll_start;
                resp_got_reg <= 1'b0;
            end
            else
            begin
                if (r_rpp)
                begin
                    resp_got_reg <= 1'b1;
                    resp_reg     <= r_dio;
                end
                // poll ends once answered and local eoi drops
                if (resp_got_reg & ~l_eoi)
                begin
                    ppip_reg <= 1'b0;
                    ppr_reg  <= resp_reg;
                end
            end
            // far side: let the bus settle before sampling the answer
            if (!rpoll)
            begin
                rpoll_cnt_reg  <= 8'h00;
                rpoll_done_reg <= 1'b0;
            end
            else if (rpoll_cnt_reg == PP_WAIT[7:0] - 8'h01)
            begin
                rpoll_done_reg <= 1'b1;
                rpoll_dio_reg  <= bus_dio_i;
            end
            else if (!rpoll_done_reg)
                rpoll_cnt_reg <= rpoll_cnt_reg + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outbound transmit word
    always @*
    begin
        x_word = {`PK_DATA_W{1'b0}};
        x_word[`PK_IFC] = lsc_reg & l_ifc;
        x_word[`PK_REN] = lsc_reg & l_ren;
        // identify is held toward the far bus for the whole poll
        x_word[`PK_ATN] = lac_reg & (l_atn | ppip_reg);
        x_word[`PK_EOI] = ppip_reg | (ls_reg & l_eoi);
        x_word[`PK_SRQ] = ~lac_reg & l_srq;
        x_word[`PK_DAV] = ls_reg & l_dav;
        x_word[`PK_RFD] = rs_reg & ~bus_nrfd_i;
        x_word[`PK_DAC] = rs_reg & ~bus_ndac_i;
        x_word[`PK_ACK] = ack_reg;
        x_word[`PK_RPP] = rpoll_done_reg;
        if (rpoll_done_reg)
            x_word[`PK_DIO_LSB+7:`PK_DIO_LSB] = rpoll_dio_reg;
        else if (ls_reg & ~ppip_reg)
            x_word[`PK_DIO_LSB+7:`PK_DIO_LSB] = bus_dio_i;
    end

    ////////////////////////////////////////////////////////////////////
    // local bus drive
    always @*
    begin
        bus_out_next         = 8'h00;
        bus_oe_next          = 8'h00;
        bus_out_next[B_IFC]  = r_ifc;
        bus_oe_next[B_IFC]   = rsc_reg;
        bus_out_next[B_REN]  = r_ren;
        bus_oe_next[B_REN]   = rsc_reg;
        bus_out_next[B_ATN]  = r_atn;
        bus_oe_next[B_ATN]   = rac_reg;
        bus_out_next[B_EOI]  = r_eoi;
        bus_oe_next[B_EOI]   = rpoll | (rs_reg & ~ppip_reg);
        bus_out_next[B_SRQ]  = r_srq;
        bus_oe_next[B_SRQ]   = lac_reg;
        bus_out_next[B_DAV]  = r_dav;
        bus_oe_next[B_DAV]   = rs_reg;
        bus_out_next[B_NRFD] = ppip_reg | ~r_rfd;
        bus_oe_next[B_NRFD]  = ppip_reg | ls_reg;
        bus_out_next[B_NDAC] = ~ls_reg | ~r_dac;
        bus_oe_next[B_NDAC]  = ls_reg | lac_reg | rac_reg;
        dio_out_next = r_dio;
        dio_oe_next  = rs_reg & ~rpoll;
        if (ppip_reg)
        begin
            // mode taken from this unit's own selector
            if (sw_ppr_latched_i)
            begin
                dio_out_next = ppr_reg;
                dio_oe_next  = 1'b1;
            end
            else
            begin
                dio_out_next = resp_reg;
                dio_oe_next  = resp_got_reg;
            end
        end
        if (!link_reg)
        begin
            bus_oe_next = 8'h00;
            dio_oe_next = 1'b0;
        end
    end

    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bus_out_o <= 8'h00;
            bus_oe_o  <= 8'h00;
            dio_out_o <= 8'h00;
            dio_oe_o  <= 1'b0;
        end
        else
        begin
            bus_out_o <= bus_out_next;
            bus_oe_o  <= bus_oe_next;
            dio_out_o <= dio_out_next;
            dio_oe_o  <= dio_oe_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // packet transmitter: frames sent back to back, one idle bit apart
    assign ser_tx_o = tx_sh_reg[0];

    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tx_sh_reg     <= {`PK_FRAME_W{1'b1}};
            tx_cnt_reg    <= 5'd0;
            tx_tim_reg    <= 8'h00;
            sent_reg      <= {`PK_DATA_W{1'b0}};
            prev_sent_reg <= {`PK_DATA_W{1'b0}};
        end
        else if (tx_tim_reg != BIT_CYC[7:0] - 8'h01)
            tx_tim_reg <= tx_tim_reg + 8'h01;
        else
        begin
            tx_tim_reg <= 8'h00;
            if (tx_cnt_reg == 5'd0)
            begin
                tx_sh_reg     <= {2'b11, ~^x_word, x_word, 1'b0};
                tx_cnt_reg    <= FRAME_LAST[4:0];
                sent_reg      <= x_word;
                prev_sent_reg <= sent_reg;
            end
            else
            begin
                tx_sh_reg  <= {1'b1, tx_sh_reg[`PK_FRAME_W-1:1]};
                tx_cnt_reg <= tx_cnt_reg - 5'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // packet receiver, link establishment and fault detection
    wire                  rx_mid  = rx_tim_reg == BIT_CYC[7:0] - 8'h01;
    // data arrives lsb first, so after all shifts parity sits on top
    wire [`PK_DATA_W-1:0] rx_data = rx_sh_reg[`PK_DATA_W-1:0];
    wire                  rx_par  = rx_sh_reg[`PK_DATA_W];
    // in loopback a frame may arrive while the next is already loaded
    wire echo_bad = selftest & ~sw6_on_i &
                    (rx_data != sent_reg) & (rx_data != prev_sent_reg);

    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_st_reg   <= RX_IDLE;
            rx_tim_reg  <= 8'h00;
            rx_cnt_reg  <= 5'd0;
            rx_sh_reg   <= {(`PK_DATA_W+1){1'b0}};
            rx_word_reg <= {`PK_DATA_W{1'b0}};
            ack_reg     <= 1'b0;
            link_reg    <= 1'b0;
            err_reg     <= 1'b0;
        end
        else
        begin
            case (rx_st_reg)
                RX_IDLE:
                begin
                    rx_cnt_reg <= 5'd0;
                    // start sampling half a bit into the start bit
                    rx_tim_reg <= {1'b0, BIT_CYC[7:1]};
                    if (!ser_rx_i)
                        rx_st_reg <= RX_BUSY;
                end
                RX_BUSY:
                begin
                    rx_tim_reg <= rx_mid ? 8'h00 : rx_tim_reg + 8'h01;
                    if (rx_mid)
                    begin
                        rx_cnt_reg <= rx_cnt_reg + 5'd1;
                        if (rx_cnt_reg == 5'd0)
                        begin
                            if (ser_rx_i)
                                rx_st_reg <= RX_IDLE;
                        end
                        else if (rx_cnt_reg <= `PK_DATA_W + 1)
                            rx_sh_reg <= {ser_rx_i, rx_sh_reg[`PK_DATA_W:1]};
                        else
                        begin
                            rx_st_reg <= RX_IDLE;
                            if (!ser_rx_i | (^rx_data == rx_par) | echo_bad)
                                err_reg <= 1'b1;
                            else
                            begin
                                rx_word_reg <= rx_data;
                                // own echo counts as a peer in loopback
                                ack_reg <= 1'b1;
                                if (rx_data[`PK_ACK])
                                    link_reg <= 1'b1;
                            end
                        end
                    end
                end
                default:
                    rx_st_reg <= RX_IDLE;
            endcase
        end
    end

    assign link_led_o = link_reg;
    assign err_led_o  = err_reg;

endmodule // bus_ext_core
`default_nettype wire

// ===== verilog/bus_ext_defs.vh
// Purpose: constants for the bus extender core
// Assumes: 50 MHz system clock
// Notes:   packet is start, data bits lsb first, odd parity, stop
//
// Contract
// - selector off: forward identify, return far response
// - poll mode comes from own selector only
// - self-test when switch 4 reads off
// - self-test with master exercises loopback paths
// - pass lights link, error only on fault
// - local bus state becomes outbound transmit signals
// - outbound signals serialized into packets to peer
// - peer packets decoded into parallel inbound signals
// - inbound signals drive matching local bus lines
// - sense/drive follows controller and source states
// - reset clears all, then link establishment starts; ppr_reg and tx_sh_reg reset to all ones
// - latched: answer from register, reset ff, reload
// - bus transceivers passive until link established
`ifndef BUS_EXT_DEFS_VH
`define BUS_EXT_DEFS_VH

`define CLK_MHZ        50
`define BIT_NS         100
`define BIT_CYC        ((`BIT_NS * `CLK_MHZ) / 1000)
`define PP_WAIT_NS     2000
`define PP_WAIT_CYC    ((`PP_WAIT_NS * `CLK_MHZ) / 1000)

// packet data field positions
`define PK_DIO_LSB     0
`define PK_IFC         8
`define PK_REN         9
`define PK_ATN         10
`define PK_EOI         11
`define PK_SRQ         12
`define PK_DAV         13
`define PK_RFD         14
`define PK_DAC         15
`define PK_ACK         16
`define PK_RPP         17
`define PK_DATA_W      18
`define PK_FRAME_W     22

`define PPR_RESET      8'hff

`endif

// ===== bench/bus_ext_core_monitor.sv
// Purpose: port checks for bus_ext_core
// Assumes: one clock, async active-low reset
// Notes:   bound into every bus_ext_core
`timescale 1ns/10ps
`default_nettype none
module bus_ext_core_monitor
(
    input wire logic       mclk_i,
    input wire logic       rst_n_i,
    input wire logic       sw_ppr_latched_i,
    input wire logic       sw4_on_i,
    input wire logic       bus_atn_i,
    input wire logic       bus_eoi_i,
    input wire logic       ser_rx_i,
    input wire logic       ser_tx_o,
    input wire logic [7:0] bus_out_o,
    input wire logic [7:0] bus_oe_o,
    input wire logic       dio_oe_o,
    input wire logic       link_led_o,
    input wire logic       err_led_o,
    input wire logic       selftest_o
);
    logic rx_seen_reg;
    logic tx_seen_reg;
    // own atn/eoi drive masks the inputs, so only a foreign poll counts
    wire  lpoll = link_led_o && bus_atn_i && bus_eoi_i && !bus_oe_o[2]
                  && !bus_oe_o[3];
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////
    // a link cannot come up before frames moved both ways
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_seen_reg <= 1'b0;
            tx_seen_reg <= 1'b0;
        end
        else
        begin
            rx_seen_reg <= rx_seen_reg | ~ser_rx_i;
            tx_seen_reg <= tx_seen_reg | ~ser_tx_o;
        end
    end
    ////////////////////////////////////////////////////////////////////
    property p_st;
        selftest_o == !sw4_on_i;
    endproperty
    a_st: assert property (p_st)
        else $error("selftest flag wrong");
    property p_passive;
        !link_led_o |-> bus_oe_o == 8'h00 && !dio_oe_o;
    endproperty
    a_passive: assert property (p_passive)
        else $error("drive early");
    property p_link_hold;
        link_led_o |=> link_led_o;
    endproperty
    a_link_hold: assert property (p_link_hold)
        else $error("link lost");
    property p_err_hold;
        err_led_o |=> err_led_o;
    endproperty
    a_err_hold: assert property (p_err_hold)
        else $error("err cleared");
    property p_rst;
        $rose(rst_n_i) |-> !link_led_o && !err_led_o ##0 ser_tx_o [*2];
    endproperty
    a_rst: assert property (p_rst)
        else $error("bad reset state");
    property p_link_cause;
        $rose(link_led_o) |-> rx_seen_reg && tx_seen_reg;
    endproperty
    a_link_cause: assert property (p_link_cause)
        else $error("link early");
    property p_poll_dio;
        lpoll && sw_ppr_latched_i |-> ##[1:4] dio_oe_o;
    endproperty
    a_poll_dio: assert property (p_poll_dio)
        else $error("no ppr");
    property p_poll_nrfd;
        lpoll |-> ##[1:4] bus_oe_o[6] && bus_out_o[6];
    endproperty
    a_poll_nrfd: assert property (p_poll_nrfd)
        else $error("no nrfd");
endmodule // bus_ext_core_monitor
bind bus_ext_core bus_ext_core_monitor mon
(
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .sw_ppr_latched_i(sw_ppr_latched_i),
    .sw4_on_i(sw4_on_i), .bus_atn_i(bus_atn_i), .bus_eoi_i(bus_eoi_i),
    .ser_rx_i(ser_rx_i), .ser_tx_o(ser_tx_o), .bus_out_o(bus_out_o),
    .bus_oe_o(bus_oe_o), .dio_oe_o(dio_oe_o), .link_led_o(link_led_o),
    .err_led_o(err_led_o), .selftest_o(selftest_o)
);
`default_nettype wire

// ===== bench/peer_model.sv
// Purpose: behavioural peer unit on the serial link
// Assumes: same frame layout and bit time as the unit
// Notes:   payload comes from the bench; ack bit is its own
`timescale 1ns/10ps
`default_nettype none
module peer_model
#(
    parameter int BIT_CYC = 5
)
(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        link_rx_i,
    input  wire logic [17:0] tx_word_i,
    output var  logic        link_tx_o,
    output var  logic [17:0] rx_word_o,
    output var  logic        got_o
);
    logic [20:0] frame;
    logic [19:0] rb;
    logic [17:0] w;
    ////////////////////////////////////////////////////////////////////
    // frames back to back; a reset cuts the frame and idles the line
    always
    begin
        @(posedge mclk_i);
        w = tx_word_i;
        w[16] = got_o;
        frame = {1'b1, ~^w, w, 1'b0};
        for (int i = 0; i < 22 && rst_n_i; i++)
        begin
            link_tx_o <= (i < 21) ? frame[i] : 1'b1;
            repeat (BIT_CYC) @(posedge mclk_i);
        end
        link_tx_o <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////
    always
    begin
        @(posedge mclk_i);
        if (!rst_n_i)
            got_o <= 1'b0;
        else if (!link_rx_i)
        begin
            repeat (BIT_CYC / 2) @(posedge mclk_i);
            for (int j = 0; j < 20; j++)
            begin
                repeat (BIT_CYC) @(posedge mclk_i);
                rb[j] = link_rx_i;
            end
            // stop high and odd ones over data plus parity
            if (rb[19] && ^rb[18:0])
            begin
                rx_word_o <= rb[17:0];
                got_o     <= 1'b1;
            end
        end
    end
endmodule // peer_model
`default_nettype wire

// ===== bench/tb.sv
// Purpose: self-checking bench for bus_ext_core
// Assumes: 50 MHz clock, peer model across the serial link
// Notes:   wired-or bus levels are rebuilt from all drivers
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        latched = 1'b1;
    logic        sw4_on = 1'b1;
    logic        sw6_on = 1'b1;
    logic        loop_sel = 1'b0;
    logic [7:0]  loc_ctl = 8'h00;
    logic [17:0] peer_word = 18'h0_0000;
    logic [7:0]  loc_dio = 8'h00;
    logic [7:0]  bus_out, bus_oe, dio_out;
    logic        dio_oe, ser_tx, peer_tx, link_led, err_led, selftest;
    logic [17:0] peer_rx;
    logic        peer_got;
    int          fails = 0;
    int          comparisons = 0;
    wire  [7:0]  ctl = loc_ctl | (bus_oe & bus_out);
    wire  [7:0]  dio = loc_dio | ({8{dio_oe}} & dio_out);
    wire         ser_rx = loop_sel ? ser_tx : peer_tx;
    always #10 mclk_i = ~mclk_i;
    bus_ext_core #(.BIT_CYC(5), .PP_WAIT(3)) dut
    (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .sw_ppr_latched_i(latched),
        .sw4_on_i(sw4_on), .sw6_on_i(sw6_on), .bus_ifc_i(ctl[0]),
        .bus_ren_i(ctl[1]), .bus_atn_i(ctl[2]), .bus_eoi_i(ctl[3]),
        .bus_srq_i(ctl[4]), .bus_dav_i(ctl[5]), .bus_nrfd_i(ctl[6]),
        .bus_ndac_i(ctl[7]), .bus_dio_i(dio), .bus_out_o(bus_out),
        .bus_oe_o(bus_oe), .dio_out_o(dio_out), .dio_oe_o(dio_oe),
        .ser_rx_i(ser_rx), .ser_tx_o(ser_tx), .link_led_o(link_led),
        .err_led_o(err_led), .selftest_o(selftest)
    );
    peer_model #(.BIT_CYC(5)) peer
    (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .link_rx_i(ser_tx),
        .tx_word_i(peer_word), .link_tx_o(peer_tx), .rx_word_o(peer_rx),
        .got_o(peer_got)
    );
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [17:0] e,
                       input logic [17:0] g);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        idle(5);
        chk("rst oe leds", 18'h0_0000,
            18'({bus_oe, dio_oe, link_led}));
        chk("rst tx", 18'h0_0001, 18'(ser_tx));
        rst_n_i = 1'b1;
        idle(20);
        chk("oe pre link", 18'h0_0000,
            18'({bus_oe, dio_oe, selftest}));
        for (int i = 0; i < 1000 && link_led !== 1'b1; i++)
            idle(1);
        chk("link", 18'h0_0006,
            18'({link_led, peer_got, err_led}));
        $display("test reset done");
    endtask
    task automatic t_out;
        loc_ctl = 8'h06;
        idle(300);
        chk("x atn ren", 18'h0_0003, 18'(peer_rx[10:9]));
        // controller now local, so local srq must stay home
        loc_ctl = 8'h12;
        idle(300);
        chk("x srq atn ren", 18'h0_0001,
            18'({peer_rx[12], peer_rx[10:9]}));
        loc_ctl = 8'h00;
        $display("test outbound done");
    endtask
    task automatic t_in;
        peer_word = 18'h0_225a;
        idle(300);
        chk("r ren dav dio", 18'h0_035a,
            18'({ctl[1], ctl[5], dio}));
        peer_word = 18'h0_0000;
        idle(300);
        chk("r released", 18'h0_0000,
            18'({ctl[1], ctl[5], dio}));
        $display("test inbound done");
    endtask
    task automatic t_latched;
        latched = 1'b1;
        peer_word = 18'h2_003c;
        loc_ctl = 8'h0c;
        idle(4);
        chk("ppr first", 18'h0_01ff, 18'({dio_oe, dio_out}));
        chk("poll nrfd", 18'h0_0001, 18'(ctl[6]));
        idle(300);
        loc_ctl = 8'h00;
        idle(300);
        peer_word = 18'h2_00c3;
        loc_ctl = 8'h0c;
        idle(4);
        chk("ppr reload", 18'h0_013c, 18'({dio_oe, dio_out}));
        loc_ctl = 8'h00;
        peer_word = 18'h0_0000;
        idle(300);
        $display("test latched done");
    endtask
    task automatic t_unlatched;
        latched = 1'b0;
        loc_ctl = 8'h0c;
        idle(4);
        chk("unl early", 18'h0_0000, 18'(dio));
        peer_word = 18'h2_0096;
        // identify stays asserted until the far answer shows
        for (int i = 0; i < 400 && dio !== 8'h96; i++)
            idle(1);
        chk("unl answer", 18'h0_0096, 18'(dio));
        loc_ctl = 8'h00;
        peer_word = 18'h0_0000;
        idle(300);
        $display("test unlatched done");
    endtask
    // far controller polls; leaves the unit remote-controlled, so run just before the self-test, which resets it
    task automatic t_farpoll;
        peer_word = 18'h0_0c00;
        loc_dio = 8'h5a;
        idle(500);
        chk("far poll drive", 18'h0_0006,
            18'({ctl[3:2], dio_oe}));
        chk("far poll answer", 18'h0_015a,
            18'({peer_rx[17], peer_rx[7:0]}));
        peer_word = 18'h0_0000;
        loc_dio = 8'h00;
        $display("test far poll done");
    endtask
    task automatic t_selftest;
        sw4_on = 1'b0;
        sw6_on = 1'b0;
        loop_sel = 1'b1;
        rst_n_i = 1'b0;
        idle(5);
        rst_n_i = 1'b1;
        loc_ctl = 8'h02;
        idle(1);
        chk("selftest", 18'h0_0001, 18'(selftest));
        for (int i = 0; i < 1500 && link_led !== 1'b1; i++)
            idle(1);
        chk("loop link err", 18'h0_0002,
            18'({link_led, err_led}));
        // a foreign stream in place of the echo is a fault
        loop_sel = 1'b0;
        peer_word = 18'h1_55aa;
        for (int i = 0; i < 1000 && err_led !== 1'b1; i++)
            idle(1);
        chk("echo fault", 18'h0_0001, 18'(err_led));
        $display("test selftest done");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        t_reset();
        t_out();
        t_in();
        t_latched();
        t_unlatched();
        t_farpoll();
        t_selftest();
        conclude();
    end
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        fails++;
        conclude();
    end
endmodule // tb
`default_nettype wire
